/* verilog/fcee_consts.svh */
`ifndef FCEE_CONSTS_SVH
`define FCEE_CONSTS_SVH

// Register byte addresses.
`define FCEE_A_STAT 8'h00
`define FCEE_A_CONF 8'h04
`define FCEE_A_CMD 8'h08
`define FCEE_A_RSRC 8'h0C
`define FCEE_A_ISTAT 8'h10
`define FCEE_A_IMASK 8'h14
`define FCEE_A_MADDR 8'h18
`define FCEE_A_NVDATA 8'h1C
`define FCEE_A_RAMDATA 8'h20

// Field positions.
`define FCEE_STAT_COMMAND_COMPLETE_FLAG 0
`define FCEE_STAT_ACCESS_ERROR_FLAG 1
`define FCEE_CONF_READY 0
`define FCEE_CONF_PART 1
`define FCEE_CMD_CODE 7:0
`define FCEE_CMD_ARG 15:8
`define FCEE_IRQ_DONE 0
`define FCEE_IRQ_ERR 1
`define FCEE_IRQ_COPY 2
`define FCEE_NV_VALID 31

// Command codes and arguments.
`define FCEE_OP_RSRC 8'h03
`define FCEE_OP_SWAP 8'h08
`define FCEE_OP_RAMFN 8'h81
`define FCEE_RSRC_VERSION 8'h01
`define FCEE_RAMFN_COPY 8'h00

// Reset values, sizes and response codes.
`define FCEE_PART_RESET 1'b1
`define FCEE_RSRC_VALUE 32'h0000_5A5A
`define FCEE_DEPTH 16
`define FCEE_LAST 4'hF
`define FCEE_RESP_OKAY 2'b00
`define FCEE_RESP_SLVERR 2'b10

`endif

/* verilog/fcee_pkg.sv */
package fcee_pkg;

	typedef enum logic [3:0]
	{
		ST_IDLE = 4'b0001,
		ST_EXEC = 4'b0010,
		ST_BOOT = 4'b0100,
		ST_COPY = 4'b1000
	} fcee_state_type;

endpackage

/* verilog/fcee_mem.sv */
`timescale 1ns/1ps
`include "fcee_consts.svh"
module fcee_mem (
	input wire logic clk,
	input wire logic wr_en,
	input wire logic [3:0] wr_addr,
	input wire logic [31:0] wr_data,
	input wire logic [3:0] rd_addr,
	output logic [31:0] rd_data
);
	logic [31:0] mem [0:`FCEE_DEPTH-1];

	// Contents survive every reset, as a storage array should.
	always_ff @(posedge clk)
	begin
		if (wr_en)
		begin
			mem[wr_addr] <= wr_data;
		end
	end

	always_ff @(posedge clk)
	begin
		rd_data <= mem[rd_addr];
	end
endmodule // fcee_mem

/* verilog/fcee_seq.sv */
`timescale 1ns/1ps
`include "fcee_consts.svh"
module fcee_seq (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic warm_rst,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic access_error_flag,
	output logic command_complete_flag,
	output logic emul_eeprom_ready_flag,
	output logic irq
);
	fcee_pkg::fcee_state_type state;
	logic [7:0] aw_addr;
	logic aw_held;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic w_held;
	logic wr_do;
	logic [31:0] wval;
	logic launch;
	logic partitioned;
	logic skip_copy;
	logic [3:0] idx;
	logic phase;
	logic [7:0] cmd_code;
	logic [7:0] cmd_arg;
	logic [31:0] rsrc_data;
	logic [2:0] istat;
	logic [2:0] imask;
	logic [3:0] mem_addr;
	logic exec_err;
	logic copy_go;
	logic copy_end;
	logic [31:0] nv_q;
	logic [31:0] ram_q;
	logic [7:0] rd_a;
	logic [31:0] rd_word;
	logic rd_ok;
	logic wr_ok;

	function automatic logic known(input logic [7:0] a);
		known = (a == `FCEE_A_STAT) || (a == `FCEE_A_CONF) || (a == `FCEE_A_CMD) || (a == `FCEE_A_RSRC) ||
			(a == `FCEE_A_ISTAT) || (a == `FCEE_A_IMASK) || (a == `FCEE_A_MADDR) ||
			(a == `FCEE_A_NVDATA) || (a == `FCEE_A_RAMDATA);
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Write channels are taken independently; the response follows both.

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_awready <= 1'b1;
			aw_held <= 1'b0;
			aw_addr <= 8'h00;
		end
		else if (s_axi_awvalid && s_axi_awready)
		begin
			s_axi_awready <= 1'b0;
			aw_held <= 1'b1;
			aw_addr <= {s_axi_awaddr[7:2], 2'b00};
		end
		else if (wr_do)
		begin
			aw_held <= 1'b0;
		end
		else if (s_axi_bvalid && s_axi_bready)
		begin
			s_axi_awready <= 1'b1;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_wready <= 1'b1;
			w_held <= 1'b0;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
		end
		else if (s_axi_wvalid && s_axi_wready)
		begin
			s_axi_wready <= 1'b0;
			w_held <= 1'b1;
			w_data <= s_axi_wdata;
			w_strb <= s_axi_wstrb;
		end
		else if (wr_do)
		begin
			w_held <= 1'b0;
		end
		else if (s_axi_bvalid && s_axi_bready)
		begin
			s_axi_wready <= 1'b1;
		end
	end

	assign wr_do = aw_held && w_held && !s_axi_bvalid;
	assign wval = w_data & {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
	assign wr_ok = known(aw_addr);

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `FCEE_RESP_OKAY;
		end
		else if (wr_do)
		begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wr_ok ? `FCEE_RESP_OKAY : `FCEE_RESP_SLVERR;
		end
		else if (s_axi_bready)
		begin
			s_axi_bvalid <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Reads answer one cycle after the address is taken.

	assign rd_a = {s_axi_araddr[7:2], 2'b00};
	assign rd_ok = known(rd_a);

	always_comb
	begin
		rd_word = 32'h0000_0000;
		if (rd_a == `FCEE_A_STAT)
		begin
			rd_word[`FCEE_STAT_COMMAND_COMPLETE_FLAG] = command_complete_flag;
			rd_word[`FCEE_STAT_ACCESS_ERROR_FLAG] = access_error_flag;
		end
		else if (rd_a == `FCEE_A_CONF)
		begin
			rd_word[`FCEE_CONF_READY] = emul_eeprom_ready_flag;
			rd_word[`FCEE_CONF_PART] = partitioned;
		end
		else if (rd_a == `FCEE_A_CMD)
		begin
			rd_word[`FCEE_CMD_CODE] = cmd_code;
			rd_word[`FCEE_CMD_ARG] = cmd_arg;
		end
		else if (rd_a == `FCEE_A_RSRC)
			rd_word = rsrc_data;
		else if (rd_a == `FCEE_A_ISTAT)
			rd_word[2:0] = istat;
		else if (rd_a == `FCEE_A_IMASK)
			rd_word[2:0] = imask;
		else if (rd_a == `FCEE_A_MADDR)
			rd_word[3:0] = mem_addr;
		else if (rd_a == `FCEE_A_RAMDATA)
			rd_word = ram_q;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `FCEE_RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_word;
			s_axi_rresp <= rd_ok ? `FCEE_RESP_OKAY : `FCEE_RESP_SLVERR;
		end
		else if (s_axi_rvalid && s_axi_rready)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Command sequencer.

	// A launch is ignored while an earlier error is still flagged.
	assign launch = wr_do && (aw_addr == `FCEE_A_CMD) && command_complete_flag && !access_error_flag &&
		(state == fcee_pkg::ST_IDLE);
	assign copy_go = (cmd_code == `FCEE_OP_RAMFN) && (cmd_arg == `FCEE_RAMFN_COPY) && partitioned;
	assign exec_err = (state == fcee_pkg::ST_EXEC) && (
		(cmd_code == `FCEE_OP_SWAP) ||
		((cmd_code == `FCEE_OP_RSRC) && (cmd_arg == `FCEE_RSRC_VERSION)) ||
		((cmd_code == `FCEE_OP_RAMFN) && !partitioned) ||
		((cmd_code != `FCEE_OP_RSRC) && (cmd_code != `FCEE_OP_RAMFN)));
	assign copy_end = (state == fcee_pkg::ST_COPY) && phase && (idx == `FCEE_LAST) && !warm_rst;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state <= fcee_pkg::ST_BOOT;
			command_complete_flag <= 1'b0;
			emul_eeprom_ready_flag <= 1'b0;
			skip_copy <= 1'b0;
			idx <= 4'h0;
			phase <= 1'b0;
		end
		else if (warm_rst)
		begin
			// The copy is cut short; the next boot marks ready without finishing it.
			state <= fcee_pkg::ST_BOOT;
			command_complete_flag <= 1'b0;
			emul_eeprom_ready_flag <= 1'b0;
			idx <= 4'h0;
			phase <= 1'b0;
			if (state == fcee_pkg::ST_COPY)
				skip_copy <= 1'b1;
		end
		else
		begin
			case (state)
				fcee_pkg::ST_BOOT:
				begin
					if (skip_copy || !partitioned)
					begin
						state <= fcee_pkg::ST_IDLE;
						emul_eeprom_ready_flag <= 1'b1;
						command_complete_flag <= 1'b1;
						skip_copy <= 1'b0;
					end
					else
						state <= fcee_pkg::ST_COPY;
				end
				fcee_pkg::ST_COPY:
				begin
					phase <= ~phase;
					if (phase)
						idx <= idx + 4'h1;
					if (copy_end)
					begin
						state <= fcee_pkg::ST_IDLE;
						emul_eeprom_ready_flag <= 1'b1;
						command_complete_flag <= 1'b1;
					end
				end
				fcee_pkg::ST_IDLE:
				begin
					if (launch)
					begin
						state <= fcee_pkg::ST_EXEC;
						command_complete_flag <= 1'b0;
					end
				end
				fcee_pkg::ST_EXEC:
				begin
					if (copy_go)
					begin
						state <= fcee_pkg::ST_COPY;
						idx <= 4'h0;
						phase <= 1'b0;
					end
					else
					begin
						state <= fcee_pkg::ST_IDLE;
						command_complete_flag <= 1'b1;
					end
				end
				default:
					state <= fcee_pkg::ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			cmd_code <= 8'h00;
			cmd_arg <= 8'h00;
		end
		else if (launch)
		begin
			cmd_code <= w_data[`FCEE_CMD_CODE];
			cmd_arg <= w_data[`FCEE_CMD_ARG];
		end
	end

	// Resource data only changes on a legal read; the version code returns nothing.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			rsrc_data <= 32'h0000_0000;
		else if (!exec_err && (state == fcee_pkg::ST_EXEC) && (cmd_code == `FCEE_OP_RSRC))
			rsrc_data <= `FCEE_RSRC_VALUE;
	end

	// Set wins over a simultaneous write-one clear.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			access_error_flag <= 1'b0;
		else
			access_error_flag <= exec_err ||
				(access_error_flag && !(wr_do && (aw_addr == `FCEE_A_STAT) && wval[`FCEE_STAT_ACCESS_ERROR_FLAG]));
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			partitioned <= `FCEE_PART_RESET;
			imask <= 3'h0;
			mem_addr <= 4'h0;
		end
		else if (wr_do && w_strb[0])
		begin
			if (aw_addr == `FCEE_A_CONF)
				partitioned <= w_data[`FCEE_CONF_PART];
			else if (aw_addr == `FCEE_A_IMASK)
				imask <= w_data[2:0];
			else if (aw_addr == `FCEE_A_MADDR)
				mem_addr <= w_data[3:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Interrupts.

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			istat <= 3'h0;
			irq <= 1'b0;
		end
		else
		begin
			istat[`FCEE_IRQ_DONE] <= (state == fcee_pkg::ST_EXEC && !copy_go && !warm_rst) || copy_end ||
				(istat[`FCEE_IRQ_DONE] && !(wr_do && (aw_addr == `FCEE_A_ISTAT) && wval[`FCEE_IRQ_DONE]));
			istat[`FCEE_IRQ_ERR] <= exec_err ||
				(istat[`FCEE_IRQ_ERR] && !(wr_do && (aw_addr == `FCEE_A_ISTAT) && wval[`FCEE_IRQ_ERR]));
			istat[`FCEE_IRQ_COPY] <= copy_end ||
				(istat[`FCEE_IRQ_COPY] && !(wr_do && (aw_addr == `FCEE_A_ISTAT) && wval[`FCEE_IRQ_COPY]));
			irq <= |(istat & imask);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Storage: invalid records copy down as zero.

	fcee_mem u_nv (
		.clk(aclk),
		.wr_en(wr_do && (aw_addr == `FCEE_A_NVDATA) && (w_strb == 4'hF)),
		.wr_addr(mem_addr),
		.wr_data(w_data),
		.rd_addr(idx),
		.rd_data(nv_q)
	);

	fcee_mem u_ram (
		.clk(aclk),
		.wr_en((state == fcee_pkg::ST_COPY) && phase && !warm_rst),
		.wr_addr(idx),
		.wr_data(nv_q[`FCEE_NV_VALID] ? nv_q : 32'h0000_0000),
		.rd_addr(mem_addr),
		.rd_data(ram_q)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Checks.

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_cut_copy;
		warm_rst && (state == fcee_pkg::ST_COPY) ##1 !warm_rst;
	endsequence

	sequence s_boot_part;
		warm_rst && !skip_copy && (state != fcee_pkg::ST_COPY) && partitioned ##1 !warm_rst && partitioned;
	endsequence

	property p_swap_err;
		launch && (w_data[`FCEE_CMD_CODE] == `FCEE_OP_SWAP) |-> ##2 access_error_flag;
	endproperty
	a_swap_err: assert property (p_swap_err) else $error("swap launch did not raise access error");

	property p_version_err;
		launch && (w_data[`FCEE_CMD_CODE] == `FCEE_OP_RSRC) && (w_data[`FCEE_CMD_ARG] == `FCEE_RSRC_VERSION)
			|-> ##2 access_error_flag && $stable(rsrc_data);
	endproperty
	a_version_err: assert property (p_version_err) else $error("version read not refused");

	property p_boot_copy;
		s_boot_part |=> (state == fcee_pkg::ST_COPY) && !command_complete_flag;
	endproperty
	a_boot_copy: assert property (p_boot_copy) else $error("copy-down did not start after warm reset");

	property p_cut_ready;
		s_cut_copy |=> emul_eeprom_ready_flag && command_complete_flag && (state == fcee_pkg::ST_IDLE);
	endproperty
	a_cut_ready: assert property (p_cut_ready) else $error("ready not asserted after cut copy-down");

	property p_ramfn_copy;
		launch && (w_data[`FCEE_CMD_CODE] == `FCEE_OP_RAMFN) && (w_data[`FCEE_CMD_ARG] == `FCEE_RAMFN_COPY)
			&& partitioned ##1 !warm_rst && partitioned |=> (state == fcee_pkg::ST_COPY);
	endproperty
	a_ramfn_copy: assert property (p_ramfn_copy) else $error("RAM function did not start copy-down");

	property p_ramfn_nopart;
		launch && (w_data[`FCEE_CMD_CODE] == `FCEE_OP_RAMFN) && !partitioned ##1 !partitioned
			|=> access_error_flag && command_complete_flag;
	endproperty
	a_ramfn_nopart: assert property (p_ramfn_nopart) else $error("unpartitioned RAM function not refused");

	property p_blocked;
		wr_do && (aw_addr == `FCEE_A_CMD) && access_error_flag && (state == fcee_pkg::ST_IDLE) && !warm_rst
			|=> (state == fcee_pkg::ST_IDLE) && $stable(cmd_code);
	endproperty
	a_blocked: assert property (p_blocked) else $error("command launched while error flagged");

	property p_copy_busy;
		(state == fcee_pkg::ST_COPY) |-> !command_complete_flag ##[1:40] (state != fcee_pkg::ST_COPY);
	endproperty
	a_copy_busy: assert property (p_copy_busy) else $error("copy-down busy flag or length wrong");

	property p_irq;
		(|(istat & imask)) |=> irq;
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt not raised");
endmodule // fcee_seq

/* dv/fcee_seq_test.sv */
`timescale 1ns/1ps
`include "fcee_consts.svh"
module fcee_seq_test;
	logic aclk = 0;
	logic aresetn = 0;
	logic warm_rst = 0;
	logic [7:0] awaddr = 0;
	logic [7:0] araddr = 0;
	logic [31:0] wdata = 0;
	logic awvalid = 0;
	logic wvalid = 0;
	logic bready = 0;
	logic arvalid = 0;
	logic rready = 0;
	logic awready, wready, bvalid, arready, rvalid, aef, ccf, erf, irq;
	logic [1:0] bresp, rresp, rs;
	logic [31:0] rdata, rd;
	logic [31:0] nv [16];
	logic [31:0] ram [16];
	logic [7:0] bad_op [3] = '{`FCEE_OP_SWAP, `FCEE_OP_RSRC, 8'h55};
	logic [7:0] bad_arg [3] = '{8'h00, `FCEE_RSRC_VERSION, 8'h00};
	int fails = 0;
	int checks_done = 0;
	int seed = 30556;

	always #4 aclk = ~aclk;

	fcee_seq fcee_seq_inst (.aclk(aclk), .aresetn(aresetn), .warm_rst(warm_rst), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.access_error_flag(aef), .command_complete_flag(ccf), .emul_eeprom_ready_flag(erf), .irq(irq));

	////////////////////////////////////////////////////////////////////////////////
	task automatic results;
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		checks_done++;
		if (s !== e)
		begin
			fails++;
			$display("BAD %s expected %h seen %h", n, e, s);
		end
	endtask

	// Each channel is released only at the edge that takes it, so a slow ready never loses an item.
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		for (i = 0; i < 100; i++)
		begin
			@(posedge aclk);
			if (awready === 1'b1)
				awvalid <= 0;
			if (wready === 1'b1)
				wvalid <= 0;
			if (bvalid === 1'b1)
				break;
		end
		rs = bresp;
		bready <= 0;
		chk("bvalid", bvalid, 1);
	endtask

	task automatic rdr(input logic [7:0] a);
		int i;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		for (i = 0; i < 100; i++)
		begin
			@(posedge aclk);
			if (arready === 1'b1)
				arvalid <= 0;
			if (rvalid === 1'b1)
				break;
		end
		rd = rdata;
		rs = rresp;
		rready <= 0;
		chk("rvalid", rvalid, 1);
	endtask

	task automatic idle;
		int i;
		repeat (3) @(posedge aclk);
		for (i = 0; i < 200 && ccf !== 1'b1; i++)
			@(posedge aclk);
		chk("complete", ccf, 1);
	endtask

	task automatic cmd(input logic [7:0] op, input logic [7:0] arg);
		wr(`FCEE_A_CMD, {16'h0000, arg, op});
		idle();
	endtask

	task automatic wreset;
		@(posedge aclk);
		warm_rst <= 1;
		@(posedge aclk);
		warm_rst <= 0;
	endtask

	task automatic load;
		for (int i = 0; i < 16; i++)
		begin
			nv[i] = $random(seed);
			wr(`FCEE_A_MADDR, i);
			wr(`FCEE_A_NVDATA, nv[i]);
		end
	endtask

	// Records without the valid bit land as zero in the emulation RAM.
	task automatic copy_model;
		for (int i = 0; i < 16; i++)
			ram[i] = nv[i][`FCEE_NV_VALID] ? nv[i] : 32'h0000_0000;
	endtask

	task automatic ramchk(input int i);
		wr(`FCEE_A_MADDR, i);
		rdr(`FCEE_A_RAMDATA);
		chk("ram", rd, ram[i]);
	endtask

	task automatic clr;
		wr(`FCEE_A_STAT, 32'h0000_0002);
		wr(`FCEE_A_ISTAT, 32'h0000_0007);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		#400000;
		fails++;
		results();
	end

	initial
	begin
		repeat (12) @(posedge aclk);
		aresetn <= 1;
		idle();
		chk("ready", erf, 1);
		rdr(`FCEE_A_CONF);
		chk("conf", rd, 32'h0000_0003);
		chk("conf resp", rs, `FCEE_RESP_OKAY);
		rdr(`FCEE_A_STAT);
		chk("stat", rd, 32'h0000_0001);
		rdr(8'h40);
		chk("unmapped resp", rs, `FCEE_RESP_SLVERR);
		chk("unmapped data", rd, 0);
		wr(8'h40, 32'h0000_0002);
		chk("unmapped wr resp", rs, `FCEE_RESP_SLVERR);
		load();
		wreset();
		idle();
		chk("ready warm", erf, 1);
		copy_model();
		for (int i = 0; i < 16; i++)
			ramchk(i);
		// New records are stored, then the copy-down is cut short by a second warm reset.
		load();
		wreset();
		repeat (3) @(posedge aclk);
		wreset();
		idle();
		chk("ready cut", erf, 1);
		ramchk(15);
		cmd(`FCEE_OP_RAMFN, `FCEE_RAMFN_COPY);
		chk("err copy", aef, 0);
		copy_model();
		for (int i = 0; i < 16; i++)
			ramchk(i);
		rdr(`FCEE_A_ISTAT);
		chk("istat copy", rd, 32'h0000_0005);
		wr(`FCEE_A_IMASK, 32'h0000_0002);
		chk("imask resp", rs, `FCEE_RESP_OKAY);
		for (int k = 0; k < 3; k++)
		begin
			cmd(bad_op[k], bad_arg[k]);
			chk("err bad", aef, 1);
			repeat (2) @(posedge aclk);
			chk("irq set", irq, 1);
			rdr(`FCEE_A_ISTAT);
			chk("istat err", rd[`FCEE_IRQ_ERR], 1);
			wr(`FCEE_A_CMD, {16'h0000, `FCEE_RAMFN_COPY, `FCEE_OP_RAMFN});
			repeat (3) @(posedge aclk);
			chk("ignored", ccf, 1);
			clr();
			repeat (3) @(posedge aclk);
			chk("irq clr", irq, 0);
			chk("err clr", aef, 0);
		end
		rdr(`FCEE_A_RSRC);
		chk("rsrc refused", rd, 32'h0000_0000);
		cmd(`FCEE_OP_RSRC, 8'h00);
		chk("rsrc ok", aef, 0);
		rdr(`FCEE_A_RSRC);
		chk("rsrc data", rd, `FCEE_RSRC_VALUE);
		cmd(`FCEE_OP_RAMFN, 8'h05);
		chk("ramfn other", aef, 0);
		wr(`FCEE_A_IMASK, 32'h0000_0000);
		wr(`FCEE_A_CONF, 32'h0000_0000);
		rdr(`FCEE_A_CONF);
		chk("conf nopart", rd, 32'h0000_0001);
		cmd(`FCEE_OP_RAMFN, `FCEE_RAMFN_COPY);
		chk("err nopart", aef, 1);
		repeat (2) @(posedge aclk);
		chk("irq masked", irq, 0);
		clr();
		results();
	end
endmodule // fcee_seq_test
